// ### inc/pwm_timer_pkg.sv
// Constants and types shared by the waveform timer design files
`default_nettype none
package pwm_timer_pkg;

	// Counter and data register values
	localparam logic [15:0] COUNTER_RESET   = 16'hfffc;  // Counter value after reset
	localparam logic [15:0] TRIGGER_RELOAD  = 16'hfffc;  // Counter load on trigger or period end
	localparam logic [15:0] TRIGGER_CAPTURE = 16'hfffd;  // Capture value 1 load on one-pulse trigger
	localparam logic [15:0] COMPARE_RESET   = 16'h8000;  // Compare registers after reset
	localparam logic [15:0] CAPTURE_RESET   = 16'h0000;  // Capture registers after reset

	// Tick divider select codes
	localparam logic [1:0] SEL_DIV4 = 2'h0;  // CPU clock divided by 4
	localparam logic [1:0] SEL_DIV2 = 2'h1;  // CPU clock divided by 2
	localparam logic [1:0] SEL_DIV8 = 2'h2;  // CPU clock divided by 8
	localparam logic [1:0] SEL_EXT  = 2'h3;  // External clock edges

	// Prescaler terminal masks, a tick fires when the low bits are all ones
	localparam logic [2:0] MASK_DIV2 = 3'h1;  // Every 2 cycles
	localparam logic [2:0] MASK_DIV4 = 3'h3;  // Every 4 cycles
	localparam logic [2:0] MASK_DIV8 = 3'h7;  // Every 8 cycles
	localparam logic [2:0] PRESC_RESET = 3'h0;  // Prescaler after reset

	// Waveform operating modes
	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_ONE_PULSE,
		MODE_PWM
	} timer_mode_t;

endpackage : pwm_timer_pkg
`default_nettype wire

// ### hw/edge_pick.sv
// Selectable rising or falling edge detector for a synchronous pin
`timescale 1ns/1ps
`default_nettype none
module edge_pick
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Pin and selection
	input  wire logic pin,       // Pin level, already synchronous
	input  wire logic rising,    // 1 picks rising edges, 0 falling
	// Result
	output logic      edge_seen  // One-cycle pulse on the chosen edge
);

	logic prev;       // Pin level one cycle ago
	logic next_prev;  // Next value of prev

	// Next state: remember the pin
	always_comb
	begin
		next_prev = pin;
	end

	// Registers; low after reset so a high pin at release reads as a rising edge
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			prev <= 1'b0;
		else
			prev <= next_prev;
	end

	// Edge decode
	assign edge_seen = rising ? (pin & ~prev) : (~pin & prev);

endmodule : edge_pick
`default_nettype wire

// ### hw/tick_source.sv
// Timer tick generator: CPU clock prescaler or external clock edges
`timescale 1ns/1ps
`default_nettype none
module tick_source
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Selection
	input  wire logic [1:0] tick_divider_select,  // Divider code
	input  wire logic       ext_clk,              // External timer clock pin
	input  wire logic       ext_clk_rising,       // 1 counts rising external edges
	input  wire logic       freeze,               // Halt: no ticks at all
	// Result
	output logic            tick                  // One-cycle timer tick enable
);

	logic [2:0] presc;       // Free-running prescaler
	logic [2:0] next_presc;  // Next prescaler value
	logic [2:0] mask;        // Terminal mask for the chosen divider
	logic       ext_edge;    // External clock edge pulse

	// External clock edge detection
	edge_pick ext_pick (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.pin       (ext_clk),
		.rising    (ext_clk_rising),
		.edge_seen (ext_edge)
	);

	// Divider decode and prescaler advance; prescaler stops in halt too
	always_comb
	begin
		next_presc = freeze ? presc : presc + 3'h1;
		if (tick_divider_select == pwm_timer_pkg::SEL_DIV2)
			mask = pwm_timer_pkg::MASK_DIV2;
		else if (tick_divider_select == pwm_timer_pkg::SEL_DIV8)
			mask = pwm_timer_pkg::MASK_DIV8;
		else
			mask = pwm_timer_pkg::MASK_DIV4;
	end

	// Prescaler register
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			presc <= pwm_timer_pkg::PRESC_RESET;
		else
			presc <= next_presc;
	end

	// Tick select: external edges or prescaler terminal count
	always_comb
	begin
		if (freeze)
			tick = 1'b0;
		else if (tick_divider_select == pwm_timer_pkg::SEL_EXT)
			tick = ext_edge;
		else
			tick = ((presc & mask) == mask);
	end

endmodule : tick_source
`default_nettype wire

// ### hw/wave_timer.sv
// Free-running 16-bit timer with capture, compare, one-pulse and PWM waveforms
`timescale 1ns/1ps
`default_nettype none
module wave_timer
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Control bits
	input  wire logic        one_pulse_select,      // One-pulse mode request
	input  wire logic        pwm_select,            // PWM mode request
	input  wire logic        after_match_level,     // Level after compare one match
	input  wire logic        in_pulse_level,        // Level during pulse / compare two level
	input  wire logic        capture1_edge_select,  // 1 rising, 0 falling
	input  wire logic        capture2_edge_select,  // 1 rising, 0 falling
	input  wire logic        capture_irq_enable,    // Capture interrupt enable
	input  wire logic        compare_irq_enable,    // Compare interrupt enable
	input  wire logic        irq_mask,              // Global interrupt mask, 1 masks
	input  wire logic [1:0]  tick_divider_select,   // Tick source code
	input  wire logic        ext_clk_rising,        // External clock edge choice
	input  wire logic        compare1_pin_enable,   // Route waveform to pin one
	input  wire logic        compare2_pin_enable,   // Route compare two to pin two, normal mode only
	// Power state
	input  wire logic        wait_state,            // Wait state, no effect on timer
	input  wire logic        halt_state,            // Halt state, timer frozen
	// Host accesses, one-cycle strobes
	input  wire logic        status_read,           // Status register read
	input  wire logic        capture1_high_read,    // Capture one high byte read
	input  wire logic        capture1_low_access,   // Capture one low byte access
	input  wire logic        capture2_high_read,    // Capture two high byte read
	input  wire logic        capture2_low_access,   // Capture two low byte access
	input  wire logic        compare1_high_write,   // Compare one high byte write
	input  wire logic        compare1_low_write,    // Compare one low byte write
	input  wire logic        compare2_high_write,   // Compare two high byte write
	input  wire logic        compare2_low_write,    // Compare two low byte write
	input  wire logic [7:0]  write_data,            // Byte written
	// Pins
	input  wire logic        capture_pin_one,       // Capture / trigger input one
	input  wire logic        capture_pin_two,       // Capture input two
	input  wire logic        ext_clk,               // External timer clock
	output logic             compare_output_pin_one,      // Waveform pin one
	output logic             compare_output_pin_one_oe,   // Pin one driven by timer
	output logic             compare_output_pin_two,      // Compare two pin
	output logic             compare_output_pin_two_oe,   // Pin two driven by timer
	// Status and data
	output logic             capture_flag_one,      // Capture flag one
	output logic             capture_flag_two,      // Capture flag two
	output logic             compare_flag_one,      // Compare flag one
	output logic             compare_flag_two,      // Compare flag two
	output logic [15:0]      capture_value_one,     // Capture register one
	output logic [15:0]      capture_value_two,     // Capture register two
	output logic [15:0]      compare_value_one,     // Compare register one
	output logic [15:0]      compare_value_two,     // Compare register two
	output logic [15:0]      counter,               // Free-running counter
	output logic             timer_irq              // Interrupt and wake request
);

	pwm_timer_pkg::timer_mode_t mode;  // Decoded operating mode
	logic tick;                        // Timer tick enable
	logic edge1;                       // Capture pin one edge
	logic edge2;                       // Capture pin two edge
	logic match1;                      // Compare one match this tick
	logic match2;                      // Compare two match this tick
	logic halt_prev;                   // Halt level one cycle ago
	logic halt_exit;                   // Halt just ended

	// State and next values
	logic [15:0] next_counter, next_cap1, next_cap2, next_cmp1, next_cmp2;
	logic [7:0]  cmp1_high, cmp2_high;            // Staged high bytes
	logic [7:0]  next_cmp1_high, next_cmp2_high;
	logic        cmp1_hold, cmp2_hold;            // Compare inhibited after high write
	logic        next_cmp1_hold, next_cmp2_hold;
	logic        cap1_hold, cap2_hold;            // Capture inhibited after high read
	logic        next_cap1_hold, next_cap2_hold;
	logic        next_capture_flag_one, next_capture_flag_two, next_compare_flag_one, next_compare_flag_two;
	logic [3:0]  clr_armed, next_clr_armed;       // Status read seen: capture_flag_one,capture_flag_two,compare_flag_one,compare_flag_two
	logic        next_pin1, next_pin2;
	logic [1:0]  halt_armed, next_halt_armed;     // Edges caught during halt

	// Compare is live only when not inhibited and a tick falls on the value
	function automatic logic hit(input logic t, input logic [15:0] c, input logic [15:0] v,
		input logic inhibit);
		hit = t & ~inhibit & (c == v);
	endfunction : hit

	// Sticky flag: set wins over the armed clear
	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		flag_next = set | (cur & ~clr);
	endfunction : flag_next

	// Tick source, frozen in halt
	tick_source ticks (
		.sys_clk             (sys_clk),
		.rst_n               (rst_n),
		.tick_divider_select (tick_divider_select),
		.ext_clk             (ext_clk),
		.ext_clk_rising      (ext_clk_rising),
		.freeze              (halt_state),
		.tick                (tick)
	);

	// Capture edge detectors
	edge_pick pick1 (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.pin       (capture_pin_one),
		.rising    (capture1_edge_select),
		.edge_seen (edge1)
	);
	edge_pick pick2 (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.pin       (capture_pin_two),
		.rising    (capture2_edge_select),
		.edge_seen (edge2)
	);

	// Mode decode; PWM overrides one-pulse
	always_comb
	begin
		if (pwm_select)
			mode = pwm_timer_pkg::MODE_PWM;
		else if (one_pulse_select)
			mode = pwm_timer_pkg::MODE_ONE_PULSE;
		else
			mode = pwm_timer_pkg::MODE_NORMAL;
	end

	assign halt_exit = halt_prev & ~halt_state;
	assign match1 = hit(tick, counter, compare_value_one, cmp1_hold);
	assign match2 = hit(tick, counter, compare_value_two, cmp2_hold);

	// Next-state logic for the whole timer; wait_state is deliberately unused here
	always_comb
	begin
		next_counter = counter;
		next_cap1 = capture_value_one;
		next_cap2 = capture_value_two;
		next_cmp1 = compare_value_one;
		next_cmp2 = compare_value_two;
		next_cmp1_high = cmp1_high;
		next_cmp2_high = cmp2_high;
		next_cmp1_hold = cmp1_hold;
		next_cmp2_hold = cmp2_hold;
		next_cap1_hold = cap1_hold;
		next_cap2_hold = cap2_hold;
		next_pin1 = compare_output_pin_one;
		next_pin2 = compare_output_pin_two;
		next_halt_armed = halt_armed;
		// Flag clear: status read arms, low-byte access clears
		next_clr_armed = clr_armed;
		if (status_read)
			next_clr_armed = next_clr_armed | {capture_flag_one, capture_flag_two,
				compare_flag_one, compare_flag_two};
		next_capture_flag_one = flag_next(capture_flag_one, 1'b0, clr_armed[3] & capture1_low_access);
		next_capture_flag_two = flag_next(capture_flag_two, 1'b0, clr_armed[2] & capture2_low_access);
		next_compare_flag_one = flag_next(compare_flag_one, 1'b0, clr_armed[1] & compare1_low_write);
		next_compare_flag_two = flag_next(compare_flag_two, 1'b0, clr_armed[0] & compare2_low_write);
		if (capture1_low_access)
			next_clr_armed[3] = 1'b0;
		if (capture2_low_access)
			next_clr_armed[2] = 1'b0;
		if (compare1_low_write)
			next_clr_armed[1] = 1'b0;
		if (compare2_low_write)
			next_clr_armed[0] = 1'b0;
		// Capture inhibit after a high-byte read, lifted by the low access
		if (capture1_high_read)
			next_cap1_hold = 1'b1;
		if (capture1_low_access)
			next_cap1_hold = 1'b0;
		if (capture2_high_read)
			next_cap2_hold = 1'b1;
		if (capture2_low_access)
			next_cap2_hold = 1'b0;
		// Compare writes: high byte stages and inhibits, low byte commits
		if (compare1_high_write)
		begin
			next_cmp1_high = write_data;
			next_cmp1_hold = 1'b1;
		end
		if (compare1_low_write)
		begin
			next_cmp1 = {cmp1_high, write_data};
			next_cmp1_hold = 1'b0;
		end
		if (compare2_high_write)
		begin
			next_cmp2_high = write_data;
			next_cmp2_hold = 1'b1;
		end
		if (compare2_low_write)
		begin
			next_cmp2 = {cmp2_high, write_data};
			next_cmp2_hold = 1'b0;
		end
		if (halt_state)
		begin
			// Counter and capture registers hold; edges only arm the capture logic, pin one edges in normal mode only
			if (edge1 && mode == pwm_timer_pkg::MODE_NORMAL)
				next_halt_armed[1] = 1'b1;
			if (edge2)
				next_halt_armed[0] = 1'b1;
		end
		else
		begin
			// Counter advance and wrap
			if (tick)
				next_counter = counter + 16'h0001;
			case (mode)
				pwm_timer_pkg::MODE_PWM:
				begin
					// Pin one driven by both compares; no compare flags
					if (match1)
						next_pin1 = after_match_level;
					if (match2)
					begin
						next_pin1 = in_pulse_level;
						next_counter = pwm_timer_pkg::TRIGGER_RELOAD;
						next_capture_flag_one = 1'b1;
					end
				end
				pwm_timer_pkg::MODE_ONE_PULSE:
				begin
					// Compare one only ends the pulse; compare two flags time only
					if (match1)
						next_pin1 = after_match_level;
					if (match2)
						next_compare_flag_two = 1'b1;
					if (edge1)
					begin
						next_counter = pwm_timer_pkg::TRIGGER_RELOAD;
						next_pin1 = in_pulse_level;
						next_capture_flag_one = 1'b1;
						next_cap1 = pwm_timer_pkg::TRIGGER_CAPTURE;
					end
				end
				default:
				begin
					// Plain compare and capture one
					if (match1)
					begin
						next_pin1 = after_match_level;
						next_compare_flag_one = 1'b1;
					end
					if (match2)
					begin
						next_pin2 = in_pulse_level;
						next_compare_flag_two = 1'b1;
					end
					if (edge1 && !cap1_hold)
					begin
						next_cap1 = counter;
						next_capture_flag_one = 1'b1;
					end
				end
			endcase
			// Capture two works in every mode; pin one captures in normal, triggers in one-pulse, is ignored in PWM
			if (edge2 && !cap2_hold)
			begin
				next_cap2 = counter;
				next_capture_flag_two = 1'b1;
			end
			// Edges armed during halt are taken with the value at exit
			if (halt_exit && halt_armed[1])
			begin
				next_cap1 = counter;
				next_capture_flag_one = 1'b1;
			end
			if (halt_exit && halt_armed[0])
			begin
				next_cap2 = counter;
				next_capture_flag_two = 1'b1;
			end
			if (halt_exit)
				next_halt_armed = 2'h0;
		end
	end

	// Timer registers; a reset wake restarts the counter from its reset value
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			counter <= pwm_timer_pkg::COUNTER_RESET;
			capture_value_one <= pwm_timer_pkg::CAPTURE_RESET;
			capture_value_two <= pwm_timer_pkg::CAPTURE_RESET;
			compare_value_one <= pwm_timer_pkg::COMPARE_RESET;
			compare_value_two <= pwm_timer_pkg::COMPARE_RESET;
			cmp1_high <= 8'h00;
			cmp2_high <= 8'h00;
			cmp1_hold <= 1'b0;
			cmp2_hold <= 1'b0;
			cap1_hold <= 1'b0;
			cap2_hold <= 1'b0;
			capture_flag_one <= 1'b0;
			capture_flag_two <= 1'b0;
			compare_flag_one <= 1'b0;
			compare_flag_two <= 1'b0;
			clr_armed <= 4'h0;
			compare_output_pin_one <= 1'b0;
			compare_output_pin_two <= 1'b0;
			halt_armed <= 2'h0;
			halt_prev <= 1'b0;
		end
		else
		begin
			counter <= next_counter;
			capture_value_one <= next_cap1;
			capture_value_two <= next_cap2;
			compare_value_one <= next_cmp1;
			compare_value_two <= next_cmp2;
			cmp1_high <= next_cmp1_high;
			cmp2_high <= next_cmp2_high;
			cmp1_hold <= next_cmp1_hold;
			cmp2_hold <= next_cmp2_hold;
			cap1_hold <= next_cap1_hold;
			cap2_hold <= next_cap2_hold;
			capture_flag_one <= next_capture_flag_one;
			capture_flag_two <= next_capture_flag_two;
			compare_flag_one <= next_compare_flag_one;
			compare_flag_two <= next_compare_flag_two;
			clr_armed <= next_clr_armed;
			compare_output_pin_one <= next_pin1;
			compare_output_pin_two <= next_pin2;
			halt_armed <= next_halt_armed;
			halt_prev <= halt_state;
		end
	end

	// Pin routing: the enables never gate the internal compare
	assign compare_output_pin_one_oe = compare1_pin_enable;
	assign compare_output_pin_two_oe = compare2_pin_enable & (mode == pwm_timer_pkg::MODE_NORMAL);

	// One request line serves interrupt and wake from wait alike
	assign timer_irq = ~irq_mask &
		((capture_irq_enable & (capture_flag_one | capture_flag_two)) |
		(compare_irq_enable & (compare_flag_one | compare_flag_two)));

	a_opm_trigger_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mode == pwm_timer_pkg::MODE_ONE_PULSE && !halt_state && edge1) |=> (counter == 16'hfffc
		&& capture_value_one == 16'hfffd && capture_flag_one && compare_output_pin_one == $past(in_pulse_level)))
		else $error("one-pulse trigger did not load counter, capture or pin");
	a_capture_irq_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(capture_flag_one && capture_irq_enable && !irq_mask) |-> timer_irq)
		else $error("capture flag one did not raise the interrupt");
	a_flag_clear_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(capture_flag_one && !clr_armed[3]) |=> capture_flag_one)
		else $error("capture flag one cleared without a status read");
	a_opm_pulse_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mode == pwm_timer_pkg::MODE_ONE_PULSE && !halt_state && match1 && !edge1)
		|=> compare_output_pin_one == $past(after_match_level))
		else $error("compare one match did not end the pulse");
	a_opm_no_compare_flag_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mode == pwm_timer_pkg::MODE_ONE_PULSE && !compare_flag_one) |=> !compare_flag_one)
		else $error("compare flag one set in one-pulse mode");
	a_pwm_no_ocf: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwm_select && !compare_flag_one && !compare_flag_two)
		|=> !compare_flag_one && !compare_flag_two)
		else $error("compare flag set in PWM mode");
	a_pwm_period_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwm_select && !halt_state && match2) |=> (counter == 16'hfffc && capture_flag_one
		&& compare_output_pin_one == $past(in_pulse_level)))
		else $error("PWM period end did not reload or flag");
	a_halt_freeze: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(halt_state && $past(halt_state)) |-> $stable(counter) && $stable(capture_value_two))
		else $error("timer moved during halt");
	a_compare_inhibit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(compare1_high_write && !compare1_low_write) |=> !match1)
		else $error("compare one matched while inhibited");
	a_pwm_ignores_pin1: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(pwm_select && edge1 && !match2 && !(halt_exit && halt_armed[1]))
		|=> $stable(capture_value_one))
		else $error("capture pin one acted in PWM mode");

endmodule : wave_timer
`default_nettype wire

// ### dv/pulse_load.sv
// Waveform load model that times the high spans on the waveform pin
`timescale 1ns/1ps
`default_nettype none
module pulse_load
(
	// Clock
	input  wire logic        sys_clk,
	// Waveform pin from the timer
	input  wire logic        wave,
	// Length in clocks of the last finished high span
	output logic [15:0]      high_len
);
	logic [15:0] run = '0;  // Clocks seen high so far
	initial high_len = '0;
	// Keep only finished spans, so a half-seen pulse never reads as a short one
	always @(posedge sys_clk)
	begin
		if (wave)
			run <= run + 16'h0001;
		else
		begin
			if (run != 16'h0000)
				high_len <= run;
			run <= 16'h0000;
		end
	end
endmodule : pulse_load
`default_nettype wire

// ### dv/wave_timer_tb_top.sv
// Self-checking bench for the one-pulse and PWM timer modes
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module wave_timer_tb_top;
	// Timer inputs at time zero; capture edge selects, interrupt enables and pin enables high, the rest low
	logic        sys_clk = '0, rst_n = '0, one_pulse_select = '0, pwm_select = '0;
	logic        after_match_level = '0, in_pulse_level = '0, capture1_edge_select = '1;
	logic        capture2_edge_select = '1, capture_irq_enable = '1, compare_irq_enable = '1;
	logic        irq_mask = '0, ext_clk_rising = '0, compare1_pin_enable = '1;
	logic        compare2_pin_enable = '1, wait_state = '0, halt_state = '0;
	logic        status_read = '0, capture1_high_read = '0, capture1_low_access = '0;
	logic        capture2_high_read = '0, capture2_low_access = '0, compare1_high_write = '0;
	logic        compare1_low_write = '0, compare2_high_write = '0, compare2_low_write = '0;
	logic        capture_pin_one = '0, capture_pin_two = '0, ext_clk = '0;
	logic [1:0]  tick_divider_select = '0;
	logic [7:0]  write_data = '0;
	// Timer outputs and bench state
	logic        compare_output_pin_one, compare_output_pin_one_oe, compare_output_pin_two;
	logic        compare_output_pin_two_oe, capture_flag_one, capture_flag_two;
	logic        compare_flag_one, compare_flag_two, timer_irq;
	logic [15:0] capture_value_one, capture_value_two, compare_value_one;
	logic [15:0] compare_value_two, counter, high_len, c0;
	int          n_errors = 0, num_checks = 0;
	wave_timer u_dut (.*);
	pulse_load u_load (.sys_clk(sys_clk), .wave(compare_output_pin_one), .high_len(high_len));
	always #12.5 sys_clk = ~sys_clk;
	// One-cycle host strobe, launched and dropped on falling edges
	task automatic pulse(ref logic s);
		@(negedge sys_clk) s = '1;
		@(negedge sys_clk) s = '0;
	endtask : pulse
	// Compare register load, high byte first
	task automatic wr(ref logic hs, ref logic ls, input logic [15:0] v);
		write_data = v[15:8];
		pulse(hs);
		write_data = v[7:0];
		pulse(ls);
	endtask : wr
	// Counter advance over 32 clocks per internal divider, with wait state on
	task automatic t_div;
		wait_state = '1;
		for (int s = 0; s < 3; s++)
		begin
			tick_divider_select = s[1:0];
			repeat (8) @(negedge sys_clk);
			c0 = counter;
			repeat (32) @(negedge sys_clk);
			`CHK(counter - c0, (s == 0) ? 16'h8 : (s == 1) ? 16'h10 : 16'h4)
		end
		// External clock, falling edges only: six falls give six counts
		tick_divider_select = 2'h3;
		c0 = counter;
		repeat (6)
		begin
			@(negedge sys_clk) ext_clk = '1;
			@(negedge sys_clk) ext_clk = '0;
		end
		@(negedge sys_clk);
		`CHK(counter - c0, 16'h6)
		// Back to a running internal tick so the halt freeze is meaningful
		tick_divider_select = 2'h1;
		wait_state = '0;
	endtask : t_div
	// Halt freezes the count; a pin two edge in halt is taken at exit
	task automatic t_halt;
		halt_state = '1;
		repeat (2) @(negedge sys_clk);
		c0 = counter;
		capture_pin_two = '1;
		repeat (20) @(negedge sys_clk);
		`CHK({counter, capture_flag_two}, {c0, 1'h0})
		halt_state = '0;
		repeat (3) @(negedge sys_clk);
		`CHK({capture_value_two, capture_flag_two, timer_irq}, {c0, 2'h3})
		pulse(status_read);
		pulse(capture2_low_access);
		`CHK(capture_flag_two, 1'h0)
	endtask : t_halt
	// One pulse at divide by two, compare one loaded with 0x10
	task automatic t_opm;
		{one_pulse_select, in_pulse_level, tick_divider_select} = 4'hd;
		write_data = 8'h00;
		pulse(compare1_high_write);
		`CHK(compare_value_one, 16'h8000)
		write_data = 8'h10;
		pulse(compare1_low_write);
		`CHK(compare_value_one, 16'h0010)
		capture_pin_one = '1;
		repeat (4) @(negedge sys_clk);
		`CHK({capture_value_one, capture_flag_one, compare_output_pin_one}, {16'hfffd, 2'h3})
		`CHK(timer_irq, 1'h1)
		`CHK({compare_output_pin_one_oe, compare_output_pin_two_oe, compare_output_pin_two}, 3'h4)
		pulse(capture1_low_access);
		`CHK(capture_flag_one, 1'h1)
		pulse(status_read);
		pulse(capture1_low_access);
		`CHK(capture_flag_one, 1'h0)
		for (int i = 0; i < 100 && compare_output_pin_one; i++)
			@(negedge sys_clk);
		@(negedge sys_clk);
		// Span is (0x10 + 5) ticks of two clocks, give or take two ticks of phase
		`CHK(high_len inside {[16'h26:16'h2e]}, 1'h1)
		`CHK(compare_flag_one, 1'h0)
		capture_pin_one = '0;
	endtask : t_opm
	// PWM with both selects set: high from match 0x10 to period end 0x30
	task automatic t_pwm;
		{pwm_select, in_pulse_level, after_match_level} = 3'h5;
		wr(compare2_high_write, compare2_low_write, 16'h0030);
		capture_pin_two = '0;
		repeat (150) @(negedge sys_clk);
		{capture_pin_one, capture_pin_two} = 2'h3;
		repeat (150) @(negedge sys_clk);
		`CHK(high_len inside {[16'h3e:16'h42]}, 1'h1)
		`CHK({capture_value_one, capture_flag_one, capture_flag_two}, {16'hfffd, 2'h3})
		`CHK({compare_flag_one, compare_flag_two}, 2'h0)
		`CHK(counter inside {[16'h0:16'h30], [16'hfffc:16'hffff]}, 1'h1)
		// Pin enable off only releases the pin
		compare1_pin_enable = '0;
		@(negedge sys_clk);
		`CHK(compare_output_pin_one_oe, 1'h0)
	endtask : t_pwm
	// Verdict and end of run
	task give_verdict;
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	// Watchdog at 2000 clocks, far beyond the roughly 520 clocks the tests need
	initial
	begin
		#50us;
		n_errors++;
		give_verdict();
	end
	// Main sequence
	initial
	begin
		repeat (6) @(negedge sys_clk);
		`CHK({counter, compare_value_one, compare_value_two}, 48'hfffc80008000)
		`CHK({capture_value_one, capture_flag_one, compare_flag_one}, 18'h0)
		rst_n = '1;
		t_div();
		t_halt();
		t_opm();
		t_pwm();
		give_verdict();
	end
endmodule : wave_timer_tb_top
`default_nettype wire
